// ---- rtl/dusp_pkg.sv ----
// shared constants, states and carriers for the two-channel serial pin block
// assumes one 20 MHz clock; every user will qualify names with the package
package dusp_pkg;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned BIT_TIME_NS = 1000;
  // bit time rounded down to whole cycles, never below one
  localparam int unsigned BIT_CYC = (BIT_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
                                    BIT_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned DIV_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned IDX_W = 3;
  localparam logic [IDX_W-1:0] LAST_IDX = 3'h7;
  localparam logic [1:0] BUF_FULL = 2'h2;
  localparam logic [1:0] BUF_EMPTY = 2'h0;
  localparam logic SER_IDLE = 1'b1;
  localparam logic SER_START = 1'b0;

  typedef enum logic [1:0] {
    DUSP_IDLE = 2'h0,
    DUSP_START = 2'h1,
    DUSP_DATA = 2'h3,
    DUSP_STOP = 2'h2
  } dusp_phase_t;

  typedef struct packed {
    dusp_phase_t phase;
    logic [DIV_W-1:0] div;
    logic [IDX_W-1:0] idx;
    logic [DATA_W-1:0] sh;
    logic ser;
  } dusp_tx_t;

  typedef struct packed {
    dusp_phase_t phase;
    logic [DIV_W-1:0] div;
    logic [IDX_W-1:0] idx;
    logic [DATA_W-1:0] sh;
    logic [DATA_W-1:0] data;
    logic valid;
  } dusp_rx_t;

  typedef struct packed {
    logic [1:0][DATA_W-1:0] buffer;
    logic wp;
    logic rp;
    logic [1:0] cnt;
    dusp_tx_t tx;
    dusp_rx_t rx;
    logic cts_q;
    logic cts_chg;
  } dusp_chan_t;

  typedef struct packed {
    logic rts_auto_en;
    logic cts_auto_en;
    logic cts_irq_en;
    logic cts_chg_clr;
    logic rts_sw;
  } dusp_ctl_t;

  typedef struct packed {
    logic cts_status;
    logic cts_irq;
  } dusp_stat_t;

  typedef struct packed {
    logic pump_off;
  } dusp_top_t;
endpackage : dusp_pkg

// ---- rtl/dusp_top.sv ----
// serial pin side of a two-channel uart: framing, flow control, pin muxing
// assumes pins already synchronous to ref_clk_i, which is the crystal clock
`timescale 1ns/10ps

module dusp_chan #(
  parameter int unsigned BIT_CYC = dusp_pkg::BIT_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic isolate_i,
  input wire dusp_pkg::dusp_ctl_t ctl_i,
  input wire logic [dusp_pkg::DATA_W-1:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic [dusp_pkg::DATA_W-1:0] rx_data_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  input wire logic serial_rx_i,
  output logic serial_tx_o,
  output logic rts_o,
  input wire logic cts_i,
  output dusp_pkg::dusp_stat_t stat_o
);
  localparam logic [dusp_pkg::DIV_W-1:0] BIT_LD = dusp_pkg::DIV_W'(BIT_CYC - 1);
  localparam logic [dusp_pkg::DIV_W-1:0] HALF_LD =
    dusp_pkg::DIV_W'((BIT_CYC / 2 < 1) ? 0 : BIT_CYC / 2 - 1);
  localparam int BIT_A = BIT_CYC;

  dusp_pkg::dusp_chan_t s_ff;
  dusp_pkg::dusp_chan_t nxt_s;
  logic push;
  logic pop;
  logic take;

  // isolation blocks both host-facing handshakes
  assign tx_ready_o = (s_ff.cnt != dusp_pkg::BUF_FULL) && !isolate_i; // RULE10
  assign rx_valid_o = s_ff.rx.valid && !isolate_i; // RULE10
  assign rx_data_o = s_ff.rx.data;
  assign serial_tx_o = s_ff.tx.ser;
  // auto mode holds off the far end while a word waits unread
  assign rts_o = ctl_i.rts_auto_en ? !s_ff.rx.valid : ctl_i.rts_sw; // RULE7
  // one driver for the whole status carrier: registered pin copy, then masked change flag
  assign stat_o = {s_ff.cts_q, s_ff.cts_chg && ctl_i.cts_irq_en}; // RULE6
  assign push = tx_valid_i && tx_ready_o;
  assign take = rx_valid_o && rx_ready_i;
  // a new character starts only while clear-to-send allows it
  assign pop = (s_ff.tx.phase == dusp_pkg::DUSP_IDLE) && (s_ff.cnt != dusp_pkg::BUF_EMPTY)
               && (!ctl_i.cts_auto_en || cts_i); // RULE6

  always_comb begin
    nxt_s = s_ff;
    if (push) begin
      nxt_s.buffer[s_ff.wp] = tx_data_i;
      nxt_s.wp = !s_ff.wp;
    end
    nxt_s.cnt = s_ff.cnt + 2'(push) - 2'(pop);
    // transmitter
    case (s_ff.tx.phase)
      dusp_pkg::DUSP_IDLE: begin
        nxt_s.tx.ser = dusp_pkg::SER_IDLE; // RULE1
        if (pop) begin
          nxt_s.tx.sh = s_ff.buffer[s_ff.rp];
          nxt_s.rp = !s_ff.rp;
          nxt_s.tx.ser = dusp_pkg::SER_START;
          nxt_s.tx.div = BIT_LD;
          nxt_s.tx.phase = dusp_pkg::DUSP_START;
        end
      end
      dusp_pkg::DUSP_START, dusp_pkg::DUSP_DATA: begin
        if (s_ff.tx.div != '0) begin
          nxt_s.tx.div = s_ff.tx.div - 1'b1;
        end else begin
          nxt_s.tx.div = BIT_LD;
          if (s_ff.tx.phase == dusp_pkg::DUSP_DATA && s_ff.tx.idx == dusp_pkg::LAST_IDX) begin
            nxt_s.tx.ser = dusp_pkg::SER_IDLE;
            nxt_s.tx.phase = dusp_pkg::DUSP_STOP;
          end else begin
            nxt_s.tx.ser = s_ff.tx.sh[0];
            nxt_s.tx.sh = {1'b0, s_ff.tx.sh[dusp_pkg::DATA_W-1:1]};
            nxt_s.tx.idx = (s_ff.tx.phase == dusp_pkg::DUSP_START) ? '0 : s_ff.tx.idx + 1'b1;
            nxt_s.tx.phase = dusp_pkg::DUSP_DATA;
          end
        end
      end
      default: begin
        if (s_ff.tx.div != '0) begin
          nxt_s.tx.div = s_ff.tx.div - 1'b1;
        end else begin
          nxt_s.tx.phase = dusp_pkg::DUSP_IDLE;
        end
      end
    endcase
    // receiver; a read clears, a completing frame sets and wins
    if (take) begin
      nxt_s.rx.valid = 1'b0;
    end
    case (s_ff.rx.phase)
      dusp_pkg::DUSP_IDLE: begin
        if (serial_rx_i == dusp_pkg::SER_START) begin
          nxt_s.rx.div = HALF_LD;
          nxt_s.rx.phase = dusp_pkg::DUSP_START;
        end
      end
      dusp_pkg::DUSP_START: begin
        if (s_ff.rx.div != '0) begin
          nxt_s.rx.div = s_ff.rx.div - 1'b1;
        end else if (serial_rx_i == dusp_pkg::SER_IDLE) begin
          // glitch shorter than half a bit is not a start
          nxt_s.rx.phase = dusp_pkg::DUSP_IDLE;
        end else begin
          nxt_s.rx.div = BIT_LD;
          nxt_s.rx.idx = '0;
          nxt_s.rx.phase = dusp_pkg::DUSP_DATA;
        end
      end
      dusp_pkg::DUSP_DATA: begin
        if (s_ff.rx.div != '0) begin
          nxt_s.rx.div = s_ff.rx.div - 1'b1;
        end else begin
          nxt_s.rx.div = BIT_LD;
          nxt_s.rx.sh = {serial_rx_i, s_ff.rx.sh[dusp_pkg::DATA_W-1:1]};
          nxt_s.rx.idx = s_ff.rx.idx + 1'b1;
          if (s_ff.rx.idx == dusp_pkg::LAST_IDX) begin
            nxt_s.rx.phase = dusp_pkg::DUSP_STOP;
          end
        end
      end
      default: begin
        if (s_ff.rx.div != '0) begin
          nxt_s.rx.div = s_ff.rx.div - 1'b1;
        end else begin
          nxt_s.rx.phase = dusp_pkg::DUSP_IDLE;
          // bad stop bit drops the word; unread words are overwritten
          if (serial_rx_i == dusp_pkg::SER_IDLE) begin
            nxt_s.rx.data = s_ff.rx.sh;
            nxt_s.rx.valid = 1'b1;
          end
        end
      end
    endcase
    // clear-to-send change flag, set wins over clear
    nxt_s.cts_q = cts_i; // RULE6
    if (ctl_i.cts_chg_clr) begin
      nxt_s.cts_chg = 1'b0;
    end
    if (cts_i != s_ff.cts_q) begin
      nxt_s.cts_chg = 1'b1; // RULE6
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s_ff <= '0;
      s_ff.tx.ser <= dusp_pkg::SER_IDLE; // RULE1
    end else begin
      s_ff <= nxt_s;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence tx_begin_s;
    s_ff.tx.phase == dusp_pkg::DUSP_IDLE ##1 s_ff.tx.phase == dusp_pkg::DUSP_START;
  endsequence

  tx_idle_mark_a: assert property ( // RULE1
    s_ff.tx.phase == dusp_pkg::DUSP_IDLE |-> serial_tx_o == dusp_pkg::SER_IDLE)
    else $error("idle transmitter not at idle level");
  start_bit_len_a: assert property ( // RULE1
    tx_begin_s |-> !serial_tx_o ##BIT_A s_ff.tx.phase == dusp_pkg::DUSP_DATA)
    else $error("start bit length wrong");
  cts_hold_tx_a: assert property ( // RULE6
    ctl_i.cts_auto_en && !cts_i && s_ff.tx.phase == dusp_pkg::DUSP_IDLE
    |=> s_ff.tx.phase == dusp_pkg::DUSP_IDLE)
    else $error("character started while clear-to-send low");
  cts_status_a: assert property ( // RULE6
    cts_i |=> stat_o.cts_status)
    else $error("status does not follow clear-to-send");
  cts_irq_flag_a: assert property ( // RULE6
    (cts_i != s_ff.cts_q) ##1 ctl_i.cts_irq_en |-> stat_o.cts_irq)
    else $error("clear-to-send change not flagged");
  rts_gpio_a: assert property ( // RULE7
    !ctl_i.rts_auto_en |-> rts_o == ctl_i.rts_sw)
    else $error("software request-to-send not passed out");
  rts_auto_a: assert property ( // RULE7
    ctl_i.rts_auto_en && s_ff.rx.valid |-> !rts_o)
    else $error("auto request-to-send asserted while word pending");
  bus_isolate_a: assert property ( // RULE10
    isolate_i |-> !tx_ready_o && !rx_valid_o && !push)
    else $error("host handshake active while isolated");
  buf_keep_a: assert property ( // RULE12
    push |=> s_ff.cnt != dusp_pkg::BUF_EMPTY)
    else $error("accepted word lost from buffer");
endmodule : dusp_chan

// Notes on behaviour
// RULE1: line transmit sits low in reset and while no character is sent.
// RULE2: far end idles line receive low; unused inputs may float low.
// RULE3: channel B receives from line input when select low, logic input when high.
// RULE4: logic receive pin of channel B is left open when line input used.
// RULE5: software asserts request-to-send before enabling automatic request-to-send.
// RULE6: clear-to-send gates transmit, shows as status and may raise an interrupt.
// RULE7: without automatic flow control, request/clear pins act as general purpose.
// RULE8: channel B transmit stream also drives a logic-level output.
// RULE9: crystal clock drives the block and is buffered out for others.
// RULE10: power-save input isolates the host data interface while asserted.
// RULE11: autosleep input with oscillator stopped switches the charge pump off.
// RULE12: both channels have independent identical signals, except B's receive select; B also has the logic-level transmit and receive pins.
module dusp_top #(
  parameter int unsigned BIT_CYC = dusp_pkg::BIT_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  output logic buffered_clock_out_o,
  input wire logic bus_isolate_in_i,
  input wire logic pump_autosleep_in_i,
  input wire logic osc_stopped_i,
  output logic pump_off_o,
  input wire dusp_pkg::dusp_ctl_t chan_a_ctl_i,
  output dusp_pkg::dusp_stat_t chan_a_stat_o,
  input wire logic [dusp_pkg::DATA_W-1:0] chan_a_tx_data_i,
  input wire logic chan_a_tx_valid_i,
  output logic chan_a_tx_ready_o,
  output logic [dusp_pkg::DATA_W-1:0] chan_a_rx_data_o,
  output logic chan_a_rx_valid_o,
  input wire logic chan_a_rx_ready_i,
  output logic chan_a_line_transmit_o,
  input wire logic chan_a_line_receive_i,
  output logic chan_a_request_to_send_out_o,
  input wire logic chan_a_clear_to_send_in_i,
  input wire dusp_pkg::dusp_ctl_t chan_b_ctl_i,
  output dusp_pkg::dusp_stat_t chan_b_stat_o,
  input wire logic [dusp_pkg::DATA_W-1:0] chan_b_tx_data_i,
  input wire logic chan_b_tx_valid_i,
  output logic chan_b_tx_ready_o,
  output logic [dusp_pkg::DATA_W-1:0] chan_b_rx_data_o,
  output logic chan_b_rx_valid_o,
  input wire logic chan_b_rx_ready_i,
  output logic chan_b_line_transmit_o,
  input wire logic chan_b_line_receive_i,
  output logic chan_b_logic_transmit_o,
  input wire logic chan_b_logic_receive_i,
  input wire logic chan_b_receive_source_select_i,
  output logic chan_b_request_to_send_out_o,
  input wire logic chan_b_clear_to_send_in_i
);
  dusp_pkg::dusp_top_t s_ff;
  dusp_pkg::dusp_top_t nxt_s;
  logic ser_tx_a;
  logic ser_tx_b;
  logic ser_rx_a;
  logic ser_rx_b;

  // line pins idle low, logic-level stream idles high
  assign ser_rx_a = !chan_a_line_receive_i;
  assign ser_rx_b = chan_b_receive_source_select_i ? chan_b_logic_receive_i
                                                   : !chan_b_line_receive_i; // RULE3
  assign chan_a_line_transmit_o = !ser_tx_a; // RULE1
  assign chan_b_line_transmit_o = !ser_tx_b; // RULE1
  assign chan_b_logic_transmit_o = ser_tx_b; // RULE8
  // plain wire copy; a real part would use a clock buffer cell here
  assign buffered_clock_out_o = ref_clk_i; // RULE9
  assign pump_off_o = s_ff.pump_off;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.pump_off = pump_autosleep_in_i && osc_stopped_i; // RULE11
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  dusp_chan #(.BIT_CYC(BIT_CYC)) u_chan_a ( // RULE12
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .isolate_i(bus_isolate_in_i),
    .ctl_i(chan_a_ctl_i),
    .tx_data_i(chan_a_tx_data_i),
    .tx_valid_i(chan_a_tx_valid_i),
    .tx_ready_o(chan_a_tx_ready_o),
    .rx_data_o(chan_a_rx_data_o),
    .rx_valid_o(chan_a_rx_valid_o),
    .rx_ready_i(chan_a_rx_ready_i),
    .serial_rx_i(ser_rx_a),
    .serial_tx_o(ser_tx_a),
    .rts_o(chan_a_request_to_send_out_o),
    .cts_i(chan_a_clear_to_send_in_i),
    .stat_o(chan_a_stat_o)
  );

  dusp_chan #(.BIT_CYC(BIT_CYC)) u_chan_b ( // RULE12
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .isolate_i(bus_isolate_in_i),
    .ctl_i(chan_b_ctl_i),
    .tx_data_i(chan_b_tx_data_i),
    .tx_valid_i(chan_b_tx_valid_i),
    .tx_ready_o(chan_b_tx_ready_o),
    .rx_data_o(chan_b_rx_data_o),
    .rx_valid_o(chan_b_rx_valid_o),
    .rx_ready_i(chan_b_rx_ready_i),
    .serial_rx_i(ser_rx_b),
    .serial_tx_o(ser_tx_b),
    .rts_o(chan_b_request_to_send_out_o),
    .cts_i(chan_b_clear_to_send_in_i),
    .stat_o(chan_b_stat_o)
  );

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  rx_src_logic_a: assert property ( // RULE3
    chan_b_receive_source_select_i |-> ser_rx_b == chan_b_logic_receive_i)
    else $error("channel B not fed from logic input");
  rx_src_line_a: assert property ( // RULE3
    !chan_b_receive_source_select_i |-> ser_rx_b == !chan_b_line_receive_i)
    else $error("channel B not fed from line input");
  logic_tx_copy_a: assert property ( // RULE8
    chan_b_logic_transmit_o != chan_b_line_transmit_o)
    else $error("logic transmit differs from line stream");
  pump_sleep_a: assert property ( // RULE11
    pump_autosleep_in_i && osc_stopped_i |=> pump_off_o)
    else $error("charge pump not switched off");
  pump_awake_a: assert property ( // RULE11
    !osc_stopped_i |=> !pump_off_o)
    else $error("charge pump off while oscillator runs");
endmodule : dusp_top

// ---- tb/dusp_term.sv ----
// terminal model: drives the receive pins and decodes line transmit frames
// assumes the bench clock and a bit length of BC cycles
`timescale 1ns/10ps
module dusp_term #(
  parameter int BC = 4
) (
  input wire logic clk_i,
  input wire logic sel_i,
  input wire logic [1:0] line_tx_i,
  output logic [1:0] line_rx_o,
  output logic logic_rx_o
);
  logic lv = 1'b1;
  logic [2:0] nz_ff = 3'h0;
  initial line_rx_o = 2'h0;
  // open pin: a changing pattern, so no quiet level passes by luck
  always @(posedge clk_i) nz_ff <= nz_ff + 3'h1;
  assign logic_rx_o = sel_i ? lv : nz_ff[0];
  task automatic put(input int ch, input logic v);
    if (ch == 2) lv <= v;
    else line_rx_o[ch] <= !v;
    repeat (BC) @(posedge clk_i);
  endtask : put
  task automatic send(input int ch, input logic [7:0] d);
    @(posedge clk_i);
    put(ch, 1'b0);
    for (int i = 0; i < 8; i++) put(ch, d[i]);
    put(ch, 1'b1);
  endtask : send
  task automatic rcv(input int ch, output logic [7:0] d, output bit ok);
    int n;
    n = 0;
    ok = 1'b0;
    while (line_tx_i[ch] !== 1'b1 && n < 400 * BC) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 400 * BC) return;
    repeat (BC / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BC) @(posedge clk_i);
      d[i] = !line_tx_i[ch];
    end
    repeat (BC) @(posedge clk_i);
    ok = (line_tx_i[ch] === 1'b0);
  endtask : rcv
endmodule : dusp_term

// ---- tb/tb_top.sv ----
// bench: pin scenarios for both channels, checks and verdict
// assumes dusp_top and the terminal model; bit length cut to 4 cycles
`timescale 1ns/10ps
module tb_top;
  localparam int BC = 4;
  logic clk = 1'b0, rst_n = 1'b0, iso = 1'b0, aps = 1'b0, osc = 1'b0, sel = 1'b0;
  logic av = 1'b0, bv = 1'b0, ar = 1'b0, br = 1'b0;
  logic [7:0] ad = 8'h00, bd = 8'h00;
  logic [1:0] cts = 2'h3;
  dusp_pkg::dusp_ctl_t ca = '0, cb = '0;
  wire dusp_pkg::dusp_stat_t sa, sb;
  wire bclk, poff, atr, btr, arv, brv, lgtx, lgrx;
  wire [7:0] ard, brd;
  wire [1:0] ltx, lrx, rts;
  logic [7:0] tv [3] = '{8'h01, 8'h80, 8'hA5};
  int fails = 0, num_checks = 0;
  always #25 clk = ~clk;
  dusp_top #(.BIT_CYC(BC)) dut_u (.ref_clk_i(clk), .rst_n_i(rst_n),
    .buffered_clock_out_o(bclk), .bus_isolate_in_i(iso), .pump_autosleep_in_i(aps),
    .osc_stopped_i(osc), .pump_off_o(poff), .chan_a_ctl_i(ca), .chan_a_stat_o(sa),
    .chan_a_tx_data_i(ad), .chan_a_tx_valid_i(av), .chan_a_tx_ready_o(atr),
    .chan_a_rx_data_o(ard), .chan_a_rx_valid_o(arv), .chan_a_rx_ready_i(ar),
    .chan_a_line_transmit_o(ltx[0]), .chan_a_line_receive_i(lrx[0]),
    .chan_a_request_to_send_out_o(rts[0]), .chan_a_clear_to_send_in_i(cts[0]),
    .chan_b_ctl_i(cb), .chan_b_stat_o(sb), .chan_b_tx_data_i(bd), .chan_b_tx_valid_i(bv),
    .chan_b_tx_ready_o(btr), .chan_b_rx_data_o(brd), .chan_b_rx_valid_o(brv),
    .chan_b_rx_ready_i(br), .chan_b_line_transmit_o(ltx[1]), .chan_b_line_receive_i(lrx[1]),
    .chan_b_logic_transmit_o(lgtx), .chan_b_logic_receive_i(lgrx),
    .chan_b_receive_source_select_i(sel), .chan_b_request_to_send_out_o(rts[1]),
    .chan_b_clear_to_send_in_i(cts[1]));
  dusp_term #(.BC(BC)) term_u (.clk_i(clk), .sel_i(sel), .line_tx_i(ltx), .line_rx_o(lrx),
    .logic_rx_o(lgrx));
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  task automatic push(input bit c, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    ad <= d;
    bd <= d;
    av <= !c;
    bv <= c;
    do begin
      @(posedge clk);
      n++;
    end while ((c ? btr : atr) !== 1'b1 && n < 999);
    av <= 1'b0;
    bv <= 1'b0;
  endtask : push
  task automatic got(input bit c, input logic [7:0] e);
    int n;
    n = 0;
    while ((c ? brv : arv) !== 1'b1 && n < 99) begin
      @(posedge clk);
      n++;
    end
    @(negedge clk);
    chk("rx data", c ? brd : ard, e);
    chk("rts held", rts[c], 1'b0);
    @(posedge clk);
    ar <= !c;
    br <= c;
    @(posedge clk);
    ar <= 1'b0;
    br <= 1'b0;
    @(negedge clk);
    chk("rts freed", rts[c], 1'b1);
  endtask : got
  task automatic t_misc();
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      aps <= k[1];
      osc <= k[0];
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("pump", poff, k == 3);
      chk("clk out", bclk, 1'b0);
    end
    $display("test misc done");
  endtask : t_misc
  task automatic t_gpio();
    for (int v = 0; v < 2; v++) begin
      @(posedge clk);
      ca.rts_sw <= v[0];
      cb.rts_sw <= !v[0];
      cts <= {!v[0], v[0]};
      repeat (2) @(posedge clk);
      #1;
      chk("rts gp", rts, {!v[0], v[0]});
      chk("cts st", {sb.cts_status, sa.cts_status}, {!v[0], v[0]});
      chk("clk out", bclk, 1'b1);
    end
    @(posedge clk);
    ca.cts_irq_en <= 1'b1;
    cb.cts_irq_en <= 1'b1;
    ca.cts_chg_clr <= 1'b1;
    cb.cts_chg_clr <= 1'b1;
    @(posedge clk);
    ca.cts_chg_clr <= 1'b0;
    cb.cts_chg_clr <= 1'b0;
    repeat (2) @(posedge clk);
    cts <= 2'h0;
    #1;
    chk("irq clr", {sb.cts_irq, sa.cts_irq}, 2'h0);
    repeat (3) @(posedge clk);
    #1;
    chk("irq set", {sb.cts_irq, sa.cts_irq}, 2'h1);
    $display("test gpio done");
  endtask : t_gpio
  task automatic t_tx();
    logic [7:0] d;
    bit ok;
    int n;
    n = 0;
    fork
      for (int k = 0; k < 3; k++) begin
        term_u.rcv(0, d, ok);
        chk("tx a", d, tv[k]);
        chk("stop idle", ok, 1'b1);
      end
      begin
        @(posedge clk);
        ad <= tv[0];
        av <= 1'b1;
        while (n < 3) begin
          @(posedge clk);
          if (atr === 1'b1) n++;
          ad <= tv[n % 3];
        end
        av <= 1'b0;
        @(negedge clk);
        chk("full", atr, 1'b0);
      end
    join
    chk("empty", atr, 1'b1);
    fork
      term_u.rcv(1, d, ok);
      begin
        push(1, 8'h6B);
        repeat (12 * BC) begin
          @(negedge clk);
          chk("logic tx", lgtx, !ltx[1]);
        end
      end
    join
    chk("tx b", d, 8'h6B);
    $display("test tx done");
  endtask : t_tx
  task automatic t_cts();
    logic [7:0] d;
    bit ok;
    @(posedge clk);
    ca.cts_auto_en <= 1'b1;
    cts <= 2'h2;
    push(0, 8'h3C);
    repeat (12 * BC) begin
      @(negedge clk);
      chk("cts hold", ltx[0], 1'b0);
    end
    @(posedge clk);
    cts <= 2'h3;
    term_u.rcv(0, d, ok);
    chk("cts go", d, 8'h3C);
    $display("test cts done");
  endtask : t_cts
  task automatic t_rx();
    ca.rts_sw <= 1'b1;
    cb.rts_sw <= 1'b1;
    @(posedge clk);
    ca.rts_auto_en <= 1'b1;
    cb.rts_auto_en <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      sel <= (k == 2);
      term_u.send(k, tv[k] ^ 8'h3C);
      got(k != 0, tv[k] ^ 8'h3C);
    end
    @(posedge clk);
    iso <= 1'b1;
    term_u.send(0, 8'h96);
    @(negedge clk);
    chk("iso rx", arv, 1'b0);
    chk("iso tx", {atr, btr}, 2'h0);
    @(posedge clk);
    iso <= 1'b0;
    got(0, 8'h96);
    $display("test rx done");
  endtask : t_rx
  initial begin
    @(posedge clk);
    @(negedge clk);
    chk("rst tx", {ltx, lgtx}, 3'h1);
    chk("rst out", {poff, atr, btr, arv, brv, rts}, 7'h30);
    @(posedge clk);
    rst_n <= 1'b1;
    t_misc();
    t_gpio();
    t_tx();
    t_cts();
    t_rx();
    close_out();
  end
  // span well above the scenarios' few hundred cycles
  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    close_out();
  end
endmodule : tb_top
